/* File: rtl/smbs_defines.vh */
// Constants for the management-bus configuration access slave.
// Assumes a 40 MHz core clock; included by bare name from the design file.
`ifndef SMBS_DEFINES_VH
`define SMBS_DEFINES_VH

// Target address: upper four bits fixed, low three from pins
`define SMBS_ADDR_HI        4'hD
`define SMBS_ADDR_HI_LSB    3

// Register store
`define SMBS_NREGS          16
`define SMBS_IDX_W          4

// Access types
`define SMBS_T_RW           3'h0
`define SMBS_T_RO           3'h1
`define SMBS_T_HWI          3'h2
`define SMBS_T_W1C          3'h3
`define SMBS_T_SW1C         3'h4
`define SMBS_T_SRW          3'h5
`define SMBS_T_SRO          3'h6

// First index of each access-type group
`define SMBS_IDX_RO         4
`define SMBS_IDX_HWI        6
`define SMBS_IDX_W1C        8
`define SMBS_IDX_SW1C       10
`define SMBS_IDX_SRW        12
`define SMBS_IDX_SRO        14
`define SMBS_NSET           4

// Clock stretch on each acknowledge the target drives (address, command, write data)
`define SMBS_CLK_NS         25
`define SMBS_STRETCH_NS     100
// Stretch counter load: 100 ns at a 25 ns core clock, sized for the 3-bit timer
`define SMBS_STRETCH_CYC    3'h4

// Link states
`define SMBS_S_IDLE         4'h0
`define SMBS_S_ADDR         4'h1
`define SMBS_S_AACK         4'h2
`define SMBS_S_CMD          4'h3
`define SMBS_S_CACK         4'h4
`define SMBS_S_WDAT         4'h5
`define SMBS_S_WACK         4'h6
`define SMBS_S_RDAT         4'h7
`define SMBS_S_RACK         4'h8

`endif

/* File: rtl/smbs_slave.v */
// Management-bus target giving an outside master byte access to a store of
// configuration registers of mixed access types.
// Assumes bus lines and address pins are asynchronous; hw_set_i, preload and
// power-on reset come from logic on ref_clk_i.
// Notes on behaviour
// R1: The block only answers as a target and never starts a transfer itself.
// R2: Every read/write register can be read and written from the bus.
// R3: Read-only and hardware-initialised registers also accept bus writes.
// R4: Address bits 0..2 come from three pins, first pin to bit 0.
// R5: Address bits 3..6 are fixed 1,0,1,1 and only a full match is answered.
// R6: Both lines are open drain and the block may hold the clock line low.
// R7: Write-one-to-clear bits clear on a one, ignore a zero, read back as held.
// R8: Sticky write-one-to-clear bits change only by clearing and hardware set.
// R9: Sticky read/write bits behave as plain storage.
// R10: Sticky bits survive the ordinary reset and clear only on power-on reset.
// R11: Transfers are start, address with direction, command, data, ack, stop.
module smbs_slave (
    input  wire         ref_clk_i,
    input  wire         srst_i,
    input  wire         por_i,
    input  wire         scl_i,
    output reg          scl_o,
    output reg          scl_oe_o,
    input  wire         sda_i,
    output reg          sda_o,
    output reg          sda_oe_o,
    input  wire [2:0]   addr_pin_i,
    input  wire [31:0]  hw_set_i,
    input  wire         preload_we_i,
    input  wire [3:0]   preload_idx_i,
    input  wire [7:0]   preload_data_i,
    output wire [127:0] cfg_regs_o,
    output reg          busy_o
);
`include "smbs_defines.vh"

    // Synchronisers; stage one is read only by stage two
    reg  [1:0] scl_s1_q, sda_s1_q;
    reg        scl_s2_q, sda_s2_q, scl_d3_q, sda_d3_q;
    reg  [2:0] apin_s1_q, apin_s2_q;

    reg  [3:0] state_q;
    reg  [3:0] cnt_q;
    reg  [7:0] sh_q;
    reg  [7:0] tx_q;
    reg        rw_q;
    reg        mnack_q;
    reg  [3:0] ptr_q;
    reg  [2:0] st_q;
    reg        wr_stb_q;
    reg  [7:0] wr_data_q;
    reg  [3:0] wr_idx_q;
    reg  [7:0] regs_q [0:15];
    wire [127:0] nxt_w;
    integer    i;

    wire scl_rise = scl_s2_q & ~scl_d3_q;
    wire scl_fall = ~scl_s2_q & scl_d3_q;
    wire start_c  = scl_s2_q & scl_d3_q & ~sda_s2_q & sda_d3_q;
    wire stop_c   = scl_s2_q & scl_d3_q & sda_s2_q & ~sda_d3_q;
    wire [6:0] my_addr = {`SMBS_ADDR_HI, apin_s2_q}; // R4 R5
    wire [3:0] ptr_inc = ptr_q + 4'h1;

    // Three-flop sampling of both bus lines, two-stage sampling of the address pins
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            scl_s1_q  <= 2'h3;
            sda_s1_q  <= 2'h3;
            scl_s2_q  <= 1'b1;
            sda_s2_q  <= 1'b1;
            scl_d3_q  <= 1'b1;
            sda_d3_q  <= 1'b1;
            apin_s1_q <= 3'h0;
            apin_s2_q <= 3'h0;
        end else begin
            scl_s1_q  <= {scl_s1_q[0], scl_i};
            sda_s1_q  <= {sda_s1_q[0], sda_i};
            scl_s2_q  <= scl_s1_q[1];
            sda_s2_q  <= sda_s1_q[1];
            scl_d3_q  <= scl_s2_q;
            sda_d3_q  <= sda_s2_q;
            apin_s1_q <= addr_pin_i;
            apin_s2_q <= apin_s1_q;
        end
    end

    // Bus protocol engine; purely reactive to master edges
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_q   <= `SMBS_S_IDLE;
            cnt_q     <= 4'h0;
            sh_q      <= 8'h00;
            tx_q      <= 8'h00;
            rw_q      <= 1'b0;
            mnack_q   <= 1'b1;
            ptr_q     <= 4'h0;
            st_q      <= 3'h0;
            wr_stb_q  <= 1'b0;
            wr_data_q <= 8'h00;
            wr_idx_q  <= 4'h0;
            sda_oe_o  <= 1'b0;
            scl_oe_o  <= 1'b0;
            sda_o     <= 1'b0;
            scl_o     <= 1'b0;
            busy_o    <= 1'b0;
        end else begin
            wr_stb_q <= 1'b0;
            sda_o    <= 1'b0; // R6
            scl_o    <= 1'b0;
            busy_o   <= (state_q != `SMBS_S_IDLE);
            // Hold clock low briefly while an ack settles
            if (st_q != 3'h0)
                st_q <= st_q - 3'h1;
            scl_oe_o <= (st_q != 3'h0); // R6
            if (stop_c) begin // R11
                state_q  <= `SMBS_S_IDLE;
                sda_oe_o <= 1'b0;
            end else if (start_c) begin // R11
                state_q  <= `SMBS_S_ADDR;
                cnt_q    <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (scl_rise) begin
                if (state_q == `SMBS_S_ADDR || state_q == `SMBS_S_CMD ||
                    state_q == `SMBS_S_WDAT) begin
                    sh_q  <= {sh_q[6:0], sda_s2_q};
                    cnt_q <= cnt_q + 4'h1;
                end else if (state_q == `SMBS_S_RACK) begin
                    mnack_q <= sda_s2_q;
                end
            end else if (scl_fall) begin
                case (state_q)
                    `SMBS_S_ADDR: begin
                        if (cnt_q == 4'h8) begin
                            if (sh_q[7:1] == my_addr) begin // R5
                                rw_q     <= sh_q[0];
                                sda_oe_o <= 1'b1;
                                st_q     <= `SMBS_STRETCH_CYC;
                                state_q  <= `SMBS_S_AACK;
                            end else begin
                                state_q  <= `SMBS_S_IDLE; // R1
                            end
                        end
                    end
                    `SMBS_S_AACK: begin
                        cnt_q <= 4'h0;
                        if (rw_q) begin
                            tx_q     <= {regs_q[ptr_q][6:0], 1'b0};
                            sda_oe_o <= ~regs_q[ptr_q][7]; // R2
                            state_q  <= `SMBS_S_RDAT;
                        end else begin
                            sda_oe_o <= 1'b0;
                            state_q  <= `SMBS_S_CMD;
                        end
                    end
                    `SMBS_S_CMD: begin
                        if (cnt_q == 4'h8) begin
                            ptr_q    <= sh_q[3:0]; // R11
                            sda_oe_o <= 1'b1;
                            st_q     <= `SMBS_STRETCH_CYC;
                            state_q  <= `SMBS_S_CACK;
                        end
                    end
                    `SMBS_S_CACK, `SMBS_S_WACK: begin
                        sda_oe_o <= 1'b0;
                        cnt_q    <= 4'h0;
                        if (state_q == `SMBS_S_WACK)
                            ptr_q <= ptr_inc;
                        state_q  <= `SMBS_S_WDAT;
                    end
                    `SMBS_S_WDAT: begin
                        if (cnt_q == 4'h8) begin
                            wr_stb_q  <= 1'b1; // R2 R3
                            wr_data_q <= sh_q;
                            wr_idx_q  <= ptr_q;
                            sda_oe_o  <= 1'b1;
                            st_q      <= `SMBS_STRETCH_CYC;
                            state_q   <= `SMBS_S_WACK;
                        end
                    end
                    `SMBS_S_RDAT: begin
                        if (cnt_q == 4'h7) begin
                            sda_oe_o <= 1'b0;
                            state_q  <= `SMBS_S_RACK;
                        end else begin
                            sda_oe_o <= ~tx_q[7];
                            tx_q     <= {tx_q[6:0], 1'b0};
                            cnt_q    <= cnt_q + 4'h1;
                        end
                    end
                    `SMBS_S_RACK: begin
                        cnt_q <= 4'h0;
                        if (!mnack_q) begin
                            ptr_q    <= ptr_inc;
                            tx_q     <= {regs_q[ptr_inc][6:0], 1'b0};
                            sda_oe_o <= ~regs_q[ptr_inc][7];
                            state_q  <= `SMBS_S_RDAT;
                        end else begin
                            // Master declined; wait for stop or restart
                            state_q  <= `SMBS_S_IDLE;
                        end
                    end
                    default: state_q <= `SMBS_S_IDLE;
                endcase
            end
        end
    end

    // One storage element per register, behaviour chosen by its access type
    genvar g;
    generate
        for (g = 0; g < `SMBS_NREGS; g = g + 1) begin : gen_reg
            localparam [2:0] TYP =
                (g >= `SMBS_IDX_SRO)  ? `SMBS_T_SRO  :
                (g >= `SMBS_IDX_SRW)  ? `SMBS_T_SRW  :
                (g >= `SMBS_IDX_SW1C) ? `SMBS_T_SW1C :
                (g >= `SMBS_IDX_W1C)  ? `SMBS_T_W1C  :
                (g >= `SMBS_IDX_HWI)  ? `SMBS_T_HWI  :
                (g >= `SMBS_IDX_RO)   ? `SMBS_T_RO   : `SMBS_T_RW;
            localparam W1C    = (TYP == `SMBS_T_W1C) || (TYP == `SMBS_T_SW1C);
            localparam LOADED = (TYP == `SMBS_T_RO) || (TYP == `SMBS_T_HWI) ||
                                (TYP == `SMBS_T_SRO);
            wire [7:0] set_b;
            reg  [7:0] reg_d;
            wire       hit = wr_stb_q && (wr_idx_q == g);
            if (W1C) begin : gen_set
                assign set_b = hw_set_i[8*(g-`SMBS_IDX_W1C) +: 8];
            end else begin : gen_noset
                assign set_b = 8'h00;
            end
            always @* begin
                reg_d = regs_q[g];
                if (LOADED && preload_we_i && preload_idx_i == g)
                    reg_d = preload_data_i;
                if (hit && W1C)
                    reg_d = reg_d & ~wr_data_q; // R7 R8
                else if (hit)
                    reg_d = wr_data_q; // R2 R3 R9
                // A hardware set in the clearing cycle wins
                reg_d = reg_d | set_b; // R7 R8
            end
            assign nxt_w[8*g +: 8] = reg_d;
            assign cfg_regs_o[8*g +: 8] = regs_q[g];
        end
    endgenerate

    // One writer for the whole store keeps the array single-driven;
    // sticky entries sit from the first sticky index up and skip plain reset
    always @(posedge ref_clk_i) begin
        for (i = 0; i < `SMBS_NREGS; i = i + 1) begin
            if (por_i || (srst_i && (i < `SMBS_IDX_SW1C)))
                regs_q[i] <= 8'h00; // R10
            else
                regs_q[i] <= nxt_w[8*i +: 8];
        end
    end

endmodule

/* File: tb/smbs_slave_sva.sv */
// Port assertions for the management-bus configuration access slave.
// Assumes it is bound to smbs_slave; scl_i is the resolved clock line.
module smbs_chk (
    input logic         ref_clk_i,
    input logic         srst_i,
    input logic         por_i,
    input logic         scl_i,
    input logic         scl_o,
    input logic         scl_oe_o,
    input logic         sda_o,
    input logic         sda_oe_o,
    input logic [31:0]  hw_set_i,
    input logic         preload_we_i,
    input logic [127:0] cfg_regs_o,
    input logic         busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    // Stretch is one fixed block of cycles, then the line is let go
    sequence s_hold;
        scl_oe_o [*4] ##1 !scl_oe_o;
    endsequence
    // Plain reset with nothing else touching the store
    sequence s_rst;
        srst_i && !por_i && !preload_we_i && hw_set_i == 32'h0;
    endsequence
    AST_SCL_OD: assert property (disable iff (srst_i) scl_oe_o |-> !scl_o)
        else $error("clock line driven high");
    AST_SDA_OD: assert property (disable iff (srst_i) sda_oe_o |-> !sda_o)
        else $error("data line driven high");
    AST_RST_IDLE: assert property (disable iff (por_i) srst_i |=> !sda_oe_o && !scl_oe_o && !busy_o)
        else $error("lines held through reset");
    AST_STK_KEEP: assert property (disable iff (por_i) s_rst |=> $stable(cfg_regs_o[127:96]))
        else $error("sticky lost on reset");
    AST_RST_CLR: assert property (disable iff (por_i) s_rst |=> cfg_regs_o[79:0] == 80'h0)
        else $error("plain register kept on reset");
    AST_POR_CLR: assert property (disable iff (srst_i)
        por_i && !preload_we_i && hw_set_i == 32'h0 |=> cfg_regs_o == 128'h0)
        else $error("store kept on power-on reset");
    AST_HW_SET: assert property (disable iff (srst_i || por_i) hw_set_i[7:0] != 8'h00 |=>
        (cfg_regs_o[71:64] & $past(hw_set_i[7:0])) == $past(hw_set_i[7:0]))
        else $error("hardware set lost");
    AST_SW1C_RISE: assert property (disable iff (srst_i || por_i) 1'b1 |=>
        (cfg_regs_o[87:80] & ~$past(cfg_regs_o[87:80]) & ~$past(hw_set_i[23:16])) == 8'h00)
        else $error("status bit set without hardware");
    AST_STRETCH: assert property (disable iff (srst_i || por_i) $rose(scl_oe_o) |-> s_hold)
        else $error("bad clock stretch");
    AST_SDA_LOW: assert property (disable iff (srst_i || por_i) $rose(sda_oe_o) |-> !scl_i)
        else $error("data pulled while clock high");
    AST_BUSY_ACK: assert property (disable iff (srst_i || por_i) $rose(scl_oe_o) |-> busy_o)
        else $error("clock held outside a transfer");
endmodule

bind smbs_slave smbs_chk chk_u (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .por_i(por_i), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .hw_set_i(hw_set_i),
    .preload_we_i(preload_we_i), .cfg_regs_o(cfg_regs_o), .busy_o(busy_o)
);

/* File: tb/smbs_mst_mdl.sv */
// Behavioural bus master for the slave's two open-drain lines.
// Assumes the bench resolves each line with a pull-up.
module smbs_mst_mdl (
    input  logic clk_i,
    input  logic scl_i,
    input  logic sda_i,
    output logic scl_oe_o,
    output logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    // Five clocks low, three high: a 200 ns bus clock, longer only while
    // the slave stretches; slave data lands one clock before release
    task automatic bit_x(input logic b, output logic r);
        int k;
        sda_oe_o <= ~b;
        repeat (5) @(posedge clk_i);
        scl_oe_o <= 1'b0;
        k = 0;
        @(posedge clk_i);
        while (!scl_i && k < 40) begin
            @(posedge clk_i);
            k++;
        end
        @(posedge clk_i);
        r = sda_i;
        @(posedge clk_i);
        scl_oe_o <= 1'b1;
    endtask
    // Start or repeated start, always from the master side
    task automatic start;
        sda_oe_o <= 1'b0;
        repeat (6) @(posedge clk_i);
        scl_oe_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        sda_oe_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        scl_oe_o <= 1'b1;
    endtask
    task automatic stop;
        sda_oe_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        scl_oe_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        sda_oe_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    // Byte MSB first, then the ninth clock for the acknowledge
    task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] q,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(nak, r);
        ack = ~r;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] ix, input logic [7:0] d,
                      output logic ok);
        logic [7:0] q;
        logic a0, a1, a2;
        start();
        xfer({a, 1'b0}, 1'b1, q, a0);
        xfer(ix, 1'b1, q, a1);
        xfer(d, 1'b1, q, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] ix, output logic [7:0] d,
                      output logic ok);
        logic [7:0] q;
        logic a0, a1, a2, x;
        start();
        xfer({a, 1'b0}, 1'b1, q, a0);
        xfer(ix, 1'b1, q, a1);
        start();
        xfer({a, 1'b1}, 1'b1, q, a2);
        xfer(8'hFF, 1'b1, d, x);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule

/* File: tb/smbs_tb.sv */
// Self-checking bench for the configuration access slave.
// Assumes pull-ups on both lines and a 40 MHz core clock.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] DEV_A = {4'hD, 3'h5};
    logic        ref_clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        por_i = 1'b1;
    logic [2:0]  addr_pin_i = 3'h0;
    logic [31:0] hw_set_i = 32'h0;
    logic        preload_we_i = 1'b0;
    logic [3:0]  preload_idx_i = 4'h0;
    logic [7:0]  preload_data_i = 8'h00;
    logic        m_scl_oe, m_sda_oe, ok;
    logic [7:0]  d;
    wire         d_scl_oe, d_sda_oe, busy_o;
    wire [127:0] cfg_regs_o;
    wire         scl_w = ~(d_scl_oe | m_scl_oe);
    wire         sda_w = ~(d_sda_oe | m_sda_oe);
    int          fail_count = 0;
    int          tests_run = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    smbs_slave dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .por_i(por_i), .scl_i(scl_w),
        .scl_o(), .scl_oe_o(d_scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe_o(d_sda_oe),
        .addr_pin_i(addr_pin_i), .hw_set_i(hw_set_i), .preload_we_i(preload_we_i),
        .preload_idx_i(preload_idx_i), .preload_data_i(preload_data_i), .cfg_regs_o(cfg_regs_o),
        .busy_o(busy_o));
    smbs_mst_mdl m_u (.clk_i(ref_clk_i), .scl_i(scl_w), .sda_i(sda_w),
        .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        if (fail_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic pulse(input bit p);
        if (p) por_i <= 1'b1;
        else srst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        por_i <= 1'b0;
        srst_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
    endtask
    // Every pin setting: exact address acked, swapped fixed bits refused
    task automatic s_addr;
        for (int p = 0; p < 8; p++) begin
            addr_pin_i <= p[2:0];
            repeat (6) @(posedge ref_clk_i);
            m_u.wr({4'hD, p[2:0]}, 8'h00, 8'(p + 48), ok);
            chk({7'h0, ok}, 8'h01);
            chk(cfg_regs_o[7:0], 8'(p + 48));
            m_u.wr({4'hB, p[2:0]}, 8'h00, 8'hEE, ok);
            chk({7'h0, ok}, 8'h00);
            chk(cfg_regs_o[7:0], 8'(p + 48));
        end
    endtask
    // Plain, read-only, hardware-initialised, sticky read/write and sticky read-only kinds all take writes
    task automatic s_rw;
        logic [3:0] ix [6] = '{4'h3, 4'h4, 4'h5, 4'h7, 4'hD, 4'hF};
        preload_idx_i  <= 4'h6;
        preload_data_i <= 8'h3C;
        preload_we_i   <= 1'b1;
        @(posedge ref_clk_i);
        preload_we_i   <= 1'b0;
        @(posedge ref_clk_i);
        chk(cfg_regs_o[55:48], 8'h3C);
        foreach (ix[i]) begin
            m_u.wr(DEV_A, {4'h0, ix[i]}, {ix[i], ~ix[i]}, ok);
            m_u.rd(DEV_A, {4'h0, ix[i]}, d, ok);
            chk(d, {ix[i], ~ix[i]});
            chk(cfg_regs_o[ix[i]*8 +: 8], {ix[i], ~ix[i]});
        end
    endtask
    // Clear-on-one kinds: ones clear, zeros keep
    task automatic s_w1c;
        for (int k = 0; k < 3; k += 2) begin
            hw_set_i <= 32'hFF << (8 * k);
            @(posedge ref_clk_i);
            hw_set_i <= 32'h0;
            m_u.wr(DEV_A, 8'(8 + k), 8'h0F, ok);
            m_u.rd(DEV_A, 8'(8 + k), d, ok);
            chk(d, 8'hF0);
        end
    endtask
    task automatic s_stk;
        m_u.wr(DEV_A, 8'h0C, 8'hA5, ok);
        m_u.wr(DEV_A, 8'h00, 8'h5A, ok);
        pulse(1'b0);
        chk(cfg_regs_o[103:96], 8'hA5);
        chk(cfg_regs_o[87:80], 8'hF0);
        chk(cfg_regs_o[7:0], 8'h00);
        chk({7'h0, busy_o}, 8'h00);
        pulse(1'b1);
        chk(cfg_regs_o[103:96], 8'h00);
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        por_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        s_addr();
        addr_pin_i <= 3'h5;
        s_rw();
        s_w1c();
        s_stk();
        end_sim();
    end
    // Watchdog well past the expected run length
    initial begin
        #2ms;
        fail_count++;
        end_sim();
    end
endmodule
